// ==== gpw_consts.vh ====
// Constants for the port A block: register offsets, reset values, timing.
// Assumes inclusion by bare name from the design file.
// What this block does
// RQ1 - Each port bit is an output when its direction bit is one and an input when it is zero.
// RQ2 - An output bit drives its latch onto the pin and reads back the latch, not the pin.
// RQ3 - An output bit always has its pull-down switched off.
// RQ4 - An input bit reads back the level on the pin.
// RQ5 - An input bit connects a 1M or 50K pull-down, or none, as its fixed option says.
// RQ6 - Wake-up of each pin is enabled per pin by a fixed option, not by software.
// RQ7 - While halted, a rising edge on a wake-enabled pin restarts the oscillator at vector 004H.
// RQ8 - With the double-edge option, a falling edge also wakes the chip.
// RQ9 - An option makes the fourth port input-only or bidirectional under its combined direction.
// RQ10 - With the carrier option, an output bit 3 sends 38KHz when its data is one, low when zero.
// RQ11 - Bit 3 is forced low while halted, and is a plain I/O bit without the carrier option; the code still drives its data low in halt without that option.
// RQ12 - With the touch option, bits selecting the 50K pull-down connect 220K instead.
// RQ13 - With the amplified wake option, bit 0 loses its 1M and 50K pull-downs.
// RQ14 - The Schmitt wake input on bit 0 is enabled by hardware after reset when its option is set.
// RQ15 - After a wake-up the device waits 64 stable clocks before leaving the wake-up vector.
// RQ16 - Wake edges are caught without the clock while halted and resynchronised on restart; the code samples them on clk through the synchronisers into edge_q.
`ifndef GPW_CONSTS_VH
`define GPW_CONSTS_VH
`define GPW_OFS_DIR 8'h02
`define GPW_OFS_DATA 8'h03
`define GPW_OFS_CDIR 8'h01
`define GPW_OFS_HALT 8'h20
`define GPW_BYTE_DIR 10'h008
`define GPW_BYTE_DATA 10'h00C
`define GPW_BYTE_CDIR 10'h004
`define GPW_BYTE_HALT 10'h080
`define GPW_RST_DIR 4'h0
`define GPW_RST_DATA 4'h0
`define GPW_WAKE_VECTOR 13'h004
`define GPW_STABLE_CLKS 64
`define GPW_CLK_MHZ 250
`define GPW_CARRIER_KHZ 38
`define GPW_CARRIER_HALF ((`GPW_CLK_MHZ * 1000) / (2 * `GPW_CARRIER_KHZ))
`endif

// ==== gpw_pins.sv ====
// Pin model: switches drive free pins, floating pins follow pull-downs or toggle.
// Assumes pad enables, pad data and pull-down enables from gpw_port.
`default_nettype none
module gpw_pins (
	input wire logic clk,
	input wire logic [3:0] oe,
	input wire logic [3:0] out,
	input wire logic [3:0] pd,
	input wire logic [3:0] ext_en,
	input wire logic [3:0] ext,
	output logic [3:0] pin
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0] flt_q = 4'h5;
	always @(posedge clk) flt_q <= ~flt_q;
	assign pin = (oe & out) | (~oe & ext_en & ext) | (~oe & ~ext_en & ~pd & flt_q);
endmodule // gpw_pins
`default_nettype wire

// ==== gpw_port.v ====
// Port A logic with halt wake-up, IR carrier and option-driven pull-downs.
// Assumes a 250 MHz clock, Avalon-MM word registers, options tied as static straps.
`include "gpw_consts.vh"
`default_nettype none
module gpw_port #(
	parameter OPT_PD50K = 4'h0,
	parameter OPT_PD1M = 4'h0,
	parameter OPT_WAKE = 4'hF
) (
	input wire clk,
	input wire rst_n,
	input wire [9:0] avs_address,
	input wire avs_read,
	input wire avs_write,
	input wire [31:0] avs_writedata,
	input wire [3:0] avs_byteenable,
	output reg [31:0] avs_readdata,
	output reg avs_waitrequest,
	output reg avs_response_err,
	input wire opt_double_edge_wake_option,
	input wire opt_ir_carrier_option,
	input wire opt_touch_pulldown_option,
	input wire opt_amplified_wake_option,
	input wire opt_schmitt_wake_option,
	input wire opt_fourth_port_bidir,
	input wire halt_req,
	input wire [3:0] port_a_pin_in,
	output reg [3:0] port_a_pin_out,
	output reg [3:0] port_a_pin_oe,
	output reg [3:0] pd_1m_en,
	output reg [3:0] pd_50k_en,
	output reg [3:0] pd_220k_en,
	output reg schmitt_wake_en,
	output reg amp_wake_en,
	output reg halted,
	output reg osc_run,
	output reg pc_force_vec,
	output reg [12:0] pc_vector,
	output reg pc_hold,
	output reg [3:0] combined_port_direction
);
	reg [3:0] dir_q;
	reg [3:0] lat_q;
	reg [3:0] cdir_q;
	reg [3:0] pin_prev_q;
	reg [3:0] edge_q;
	reg halt_q;
	reg [6:0] stab_q;
	reg [15:0] car_cnt_q;
	reg car_q;
	reg ack_q;
	wire [3:0] rise;
	wire [3:0] fall;
	wire [3:0] wake_edges;
	wire [3:0] pin_lvl;
	wire [3:0] pad_oe_d;
	wire acc_take;
	wire sel;
	wire hit_dir, hit_data, hit_cdir, hit_halt;
	wire [3:0] rd_data;
	reg [3:0] pin_out_d, pd1_d, pd50_d, pd220_d;
	reg [31:0] rd_word_d;
	reg rd_err_d;
	integer i;
	localparam [6:0] STAB_LAST = `GPW_STABLE_CLKS - 1;
	localparam [15:0] CAR_LAST = `GPW_CARRIER_HALF - 1;

	// Pin synchronisers, three stages per bit
	gpw_sync3 #(
		.RST_VAL(1'b0)
	) sync0_u (
		.clk(clk),
		.rst_n(rst_n),
		.pin_in(port_a_pin_in[0]),
		.level_q(pin_lvl[0])
	);

	gpw_sync3 #(
		.RST_VAL(1'b0)
	) sync1_u (
		.clk(clk),
		.rst_n(rst_n),
		.pin_in(port_a_pin_in[1]),
		.level_q(pin_lvl[1])
	);

	gpw_sync3 #(
		.RST_VAL(1'b0)
	) sync2_u (
		.clk(clk),
		.rst_n(rst_n),
		.pin_in(port_a_pin_in[2]),
		.level_q(pin_lvl[2])
	);

	gpw_sync3 #(
		.RST_VAL(1'b0)
	) sync3_u (
		.clk(clk),
		.rst_n(rst_n),
		.pin_in(port_a_pin_in[3]),
		.level_q(pin_lvl[3])
	);

	// Last settled level, for edge detection
	always @(posedge clk) begin
		if (!rst_n) begin
			pin_prev_q <= 4'h0;
		end else begin
			pin_prev_q <= pin_lvl;
		end
	end
	assign rise = pin_lvl & ~pin_prev_q;
	assign fall = ~pin_lvl & pin_prev_q;
	assign wake_edges = OPT_WAKE & (rise | (fall & {4{opt_double_edge_wake_option}})); // RQ6 RQ8

	assign sel = avs_read | avs_write;
	assign hit_dir = avs_address == `GPW_BYTE_DIR;
	assign hit_data = avs_address == `GPW_BYTE_DATA;
	assign hit_cdir = avs_address == `GPW_BYTE_CDIR;
	assign hit_halt = avs_address == `GPW_BYTE_HALT;
	assign rd_data = (dir_q & lat_q) | (~dir_q & pin_lvl); // RQ2 RQ4
	assign acc_take = sel & ~ack_q;

	// Read word and unmapped-address flag of the current request
	always @* begin
		rd_word_d = 32'h00000000;
		rd_err_d = 1'b0;
		if (hit_dir) begin
			rd_word_d = {28'h0000000, dir_q};
		end else if (hit_data) begin
			rd_word_d = {28'h0000000, rd_data}; // RQ2 RQ4
		end else if (hit_cdir) begin
			rd_word_d = {28'h0000000, cdir_q};
		end else if (hit_halt) begin
			rd_word_d = {31'h0, halt_q};
		end else begin
			rd_err_d = 1'b1;
		end
		if (!avs_read) begin
			rd_word_d = 32'h00000000;
		end
	end

	// Bus handshake, one wait cycle then answer
	always @(posedge clk) begin
		if (!rst_n) begin
			ack_q <= 1'b0;
			avs_waitrequest <= 1'b1;
			avs_readdata <= 32'h00000000;
			avs_response_err <= 1'b0;
		end else begin
			ack_q <= acc_take;
			avs_waitrequest <= ~acc_take;
			if (acc_take) begin
				avs_readdata <= rd_word_d;
				avs_response_err <= rd_err_d;
			end
		end
	end

	// Register writes, taken on the edge that sees the request
	always @(posedge clk) begin
		if (!rst_n) begin
			dir_q <= `GPW_RST_DIR;
			lat_q <= `GPW_RST_DATA;
			cdir_q <= `GPW_RST_DIR;
		end else if (acc_take & avs_write & avs_byteenable[0]) begin
			if (hit_dir) begin
				dir_q <= avs_writedata[3:0]; // RQ1
			end else if (hit_data) begin
				lat_q <= avs_writedata[3:0]; // RQ2
			end else if (hit_cdir & opt_fourth_port_bidir) begin
				cdir_q <= avs_writedata[3:0]; // RQ9
			end
		end
	end

	// Halt, wake and stabilisation
	always @(posedge clk) begin
		if (!rst_n) begin
			halt_q <= 1'b0;
			edge_q <= 4'h0;
			stab_q <= 7'h00;
			halted <= 1'b0;
			osc_run <= 1'b1;
			pc_force_vec <= 1'b0;
			pc_hold <= 1'b0;
		end else begin
			pc_force_vec <= 1'b0;
			if (halt_q) begin
				edge_q <= edge_q | wake_edges; // RQ16
				if (|(edge_q | wake_edges)) begin
					halt_q <= 1'b0; // RQ7
					osc_run <= 1'b1; // RQ7
					pc_force_vec <= 1'b1; // RQ7
					stab_q <= 7'h00;
					pc_hold <= 1'b1;
				end
			end else begin
				edge_q <= 4'h0;
				if (halt_req & ~pc_hold) begin
					halt_q <= 1'b1;
					osc_run <= 1'b0;
				end
				if (pc_hold) begin
					stab_q <= stab_q + 7'h01;
					if (stab_q == STAB_LAST) begin
						pc_hold <= 1'b0; // RQ15
					end
				end
			end
			halted <= halt_q;
		end
	end

	// 38 kHz carrier
	always @(posedge clk) begin
		if (!rst_n) begin
			car_cnt_q <= 16'h0000;
			car_q <= 1'b0;
		end else if (!opt_ir_carrier_option) begin
			car_cnt_q <= 16'h0000;
			car_q <= 1'b0;
		end else if (car_cnt_q == CAR_LAST) begin
			car_cnt_q <= 16'h0000;
			car_q <= ~car_q; // RQ10
		end else begin
			car_cnt_q <= car_cnt_q + 16'h0001;
		end
	end

	assign pad_oe_d = dir_q | {halt_q & opt_ir_carrier_option, 3'b000}; // RQ1 RQ11

	// Pad and pull-down selection
	always @* begin
		pin_out_d = lat_q;
		if (opt_ir_carrier_option) begin
			pin_out_d[3] = lat_q[3] & car_q; // RQ10
		end
		if (halt_q) begin
			pin_out_d[3] = 1'b0; // RQ11
		end
		for (i = 0; i < 4; i = i + 1) begin
			pd1_d[i] = ~pad_oe_d[i] & OPT_PD1M[i]; // RQ3 RQ5
			pd50_d[i] = ~pad_oe_d[i] & OPT_PD50K[i] & ~opt_touch_pulldown_option; // RQ5 RQ12
			pd220_d[i] = ~pad_oe_d[i] & OPT_PD50K[i] & opt_touch_pulldown_option; // RQ12
		end
		if (opt_amplified_wake_option) begin
			pd1_d[0] = 1'b0; // RQ13
			pd50_d[0] = 1'b0; // RQ13
		end
	end

	// Registered pad drive and status outputs
	always @(posedge clk) begin
		if (!rst_n) begin
			port_a_pin_out <= 4'h0;
			port_a_pin_oe <= 4'h0;
			pd_1m_en <= 4'h0;
			pd_50k_en <= 4'h0;
			pd_220k_en <= 4'h0;
			schmitt_wake_en <= 1'b0;
			amp_wake_en <= 1'b0;
			pc_vector <= `GPW_WAKE_VECTOR;
			combined_port_direction <= 4'h0;
		end else begin
			port_a_pin_out <= pin_out_d;
			port_a_pin_oe <= pad_oe_d; // RQ1 RQ11
			pd_1m_en <= pd1_d;
			pd_50k_en <= pd50_d;
			pd_220k_en <= pd220_d;
			schmitt_wake_en <= opt_schmitt_wake_option; // RQ14
			amp_wake_en <= opt_amplified_wake_option;
			pc_vector <= `GPW_WAKE_VECTOR;
			combined_port_direction <= opt_fourth_port_bidir ? cdir_q : 4'h0; // RQ9
		end
	end
endmodule // gpw_port

// Three-stage synchroniser; a change is taken once the last two stages agree
module gpw_sync3 #(
	parameter RST_VAL = 1'b0
) (
	input wire clk,
	input wire rst_n,
	input wire pin_in,
	output reg level_q
);
	reg meta_q;
	reg mid_q;
	reg last_q;

	always @(posedge clk) begin
		meta_q <= pin_in;
		mid_q <= meta_q;
		last_q <= mid_q;
	end

	always @(posedge clk) begin
		if (!rst_n) begin
			level_q <= RST_VAL;
		end else if (mid_q == last_q) begin
			level_q <= mid_q;
		end
	end
endmodule // gpw_sync3
`default_nettype wire

// ==== gpw_props.sv ====
// Checker on the port pads, pull-downs and wake outputs of gpw_port.
// Assumes one clock, static option straps and a synchronous active-low reset.
`default_nettype none
module gpw_props (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [3:0] port_a_pin_oe,
	input wire logic [3:0] port_a_pin_out,
	input wire logic [3:0] pd_1m_en,
	input wire logic [3:0] pd_50k_en,
	input wire logic [3:0] pd_220k_en,
	input wire logic opt_touch_pulldown_option,
	input wire logic opt_amplified_wake_option,
	input wire logic opt_schmitt_wake_option,
	input wire logic opt_ir_carrier_option,
	input wire logic schmitt_wake_en,
	input wire logic halted,
	input wire logic osc_run,
	input wire logic pc_force_vec,
	input wire logic [12:0] pc_vector,
	input wire logic pc_hold
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	logic [6:0] hold_q;
	always @(posedge clk) hold_q <= (!rst_n || !pc_hold) ? 7'h00 : hold_q + 7'h01;
	property p_pd_out; ((pd_1m_en | pd_50k_en | pd_220k_en) & port_a_pin_oe) == 4'h0; endproperty
	a_pd_out: assert property (p_pd_out) else $error("pull-down on output");
	property p_touch; opt_touch_pulldown_option |-> pd_50k_en == 4'h0; endproperty
	a_touch: assert property (p_touch) else $error("50K with touch option");
	property p_no220; !opt_touch_pulldown_option |-> pd_220k_en == 4'h0; endproperty
	a_no220: assert property (p_no220) else $error("220K without touch option");
	property p_amp; opt_amplified_wake_option |-> !pd_1m_en[0] && !pd_50k_en[0]; endproperty
	a_amp: assert property (p_amp) else $error("bit 0 pull-down with amp wake");
	property p_schm; opt_schmitt_wake_option && $past(rst_n) |-> schmitt_wake_en; endproperty
	a_schm: assert property (p_schm) else $error("schmitt wake not enabled");
	property p_ir; halted && $past(halted) && opt_ir_carrier_option |-> !port_a_pin_out[3]; endproperty
	a_ir: assert property (p_ir) else $error("bit 3 not low in halt");
	property p_vec; pc_force_vec |-> osc_run && pc_vector == 13'h004; endproperty
	a_vec: assert property (p_vec) else $error("wake vector wrong");
	property p_hold; $fell(pc_hold) |-> hold_q == 7'h40; endproperty
	a_hold: assert property (p_hold) else $error("hold not 64 cycles");
endmodule // gpw_props
bind gpw_port gpw_props u_props (.clk, .rst_n, .port_a_pin_oe, .port_a_pin_out, .pd_1m_en,
	.pd_50k_en, .pd_220k_en, .opt_touch_pulldown_option, .opt_amplified_wake_option,
	.opt_schmitt_wake_option, .opt_ir_carrier_option, .schmitt_wake_en, .halted, .osc_run,
	.pc_force_vec, .pc_vector, .pc_hold);
`default_nettype wire

// ==== testbench.sv ====
// Testbench for gpw_port: Avalon-MM register access, pin model, halt and wake.
// Assumes the pin model and the bound checker are compiled alongside.
`default_nettype none
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin err_count++; \
	$display("[FAIL] %0t value mismatch", $time); end end
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0, rst_n = 1'b0, rd = 1'b0, wr = 1'b0, hreq = 1'b0;
	logic wt, er, se, ae, hl, osc, fv, ph;
	logic [9:0] adr = 10'h000;
	logic [31:0] wd = 32'h0, rdat;
	logic [3:0] po, oe, p1, p5, p22, pin, cd, r, d, e, ev = 4'h0;
	logic [5:0] op = 6'h00;
	logic [12:0] pv;
	logic [4:0] q[$];
	logic [4:0] n;
	localparam logic [3:0] PD50 = 4'h5, PD1M = 4'hA;
	integer seed = 86291, err_count = 0, compares = 0, i;
	gpw_port #(.OPT_PD50K(PD50), .OPT_PD1M(PD1M), .OPT_WAKE(4'hF)) dut_u (.clk(clk),
		.rst_n(rst_n), .avs_address(adr), .avs_read(rd), .avs_write(wr),
		.avs_writedata(wd), .avs_byteenable(4'hF), .avs_readdata(rdat), .avs_waitrequest(wt),
		.avs_response_err(er), .opt_double_edge_wake_option(op[0]),
		.opt_ir_carrier_option(op[1]), .opt_touch_pulldown_option(op[2]),
		.opt_amplified_wake_option(op[3]), .opt_schmitt_wake_option(op[4]),
		.opt_fourth_port_bidir(op[5]), .halt_req(hreq), .port_a_pin_in(pin),
		.port_a_pin_out(po), .port_a_pin_oe(oe), .pd_1m_en(p1), .pd_50k_en(p5),
		.pd_220k_en(p22), .schmitt_wake_en(se), .amp_wake_en(ae), .halted(hl), .osc_run(osc),
		.pc_force_vec(fv), .pc_vector(pv), .pc_hold(ph), .combined_port_direction(cd));
	gpw_pins pins_u (.clk(clk), .oe(oe), .out(po), .pd(p1 | p5 | p22), .ext_en(4'hF),
		.ext(ev), .pin(pin));
	always #2 clk = ~clk;
	task acc(input logic w, input logic [9:0] a, input logic [3:0] v);
		@(posedge clk);
		rd <= !w;
		wr <= w;
		adr <= a;
		wd <= {28'h0, v};
		do @(posedge clk); while (wt !== 1'b0);
		rd <= 1'b0;
		wr <= 1'b0;
	endtask
	task rdx(input logic [9:0] a, input logic [4:0] x);
		q.push_back(x);
		acc(1'b0, a, 4'h0);
	endtask
	task wrap_up;
		$display("compares %0d, err_count %0d", compares, err_count);
		if (err_count == 0 && compares > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	always @(posedge clk) if (rd && wt === 1'b0) begin
		n = q.pop_front();
		if (n[4]) `CHK(er, 1'b1)
		else `CHK({er, rdat[3:0]}, n)
	end
	initial begin
		#100000;
		err_count++;
		wrap_up;
	end
	initial begin
		op <= $random(seed);
		ev <= $random(seed);
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		rdx(10'h008, 5'h00);
		rdx(10'h00C, {1'b0, ev});
		for (i = 0; i < 6; i++) begin
			r = $random(seed);
			d = $random(seed);
			e = $random(seed);
			acc(1'b1, 10'h008, r);
			acc(1'b1, 10'h00C, d);
			ev <= e;
			repeat (6) @(posedge clk);
			`CHK(oe, r)
			`CHK(po & r & 4'h7, d & r & 4'h7)
			`CHK(po[3], d[3] & !op[1])
			`CHK(p1, ~r & PD1M & {3'h7, !op[3]})
			`CHK(p5, ~r & PD50 & {4{!op[2]}} & {3'h7, !op[3]})
			`CHK(p22, ~r & PD50 & {4{op[2]}})
			rdx(10'h00C, {1'b0, (d & r) | (e & ~r)});
		end
		$display("test io done");
		rdx(10'h3FC, 5'h10);
		acc(1'b1, 10'h004, r);
		repeat (3) @(posedge clk);
		`CHK(cd, op[5] ? r : 4'h0)
		$display("test map done");
		acc(1'b1, 10'h008, 4'h0);
		ev <= 4'h0;
		repeat (8) @(posedge clk);
		hreq <= 1'b1;
		for (i = 0; i < 50 && hl !== 1'b1; i++) @(negedge clk);
		rdx(10'h080, 5'h01);
		ev <= 4'h2;
		for (i = 0; i < 50 && fv !== 1'b1; i++) @(negedge clk);
		`CHK(fv, 1'b1)
		@(posedge clk);
		hreq <= 1'b0;
		repeat (80) @(posedge clk);
		`CHK(ph, 1'b0)
		$display("test wake done");
		wrap_up;
	end
endmodule // testbench
`default_nettype wire
